// *** rfid_protocol_option_regs.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Crc-absent bit set means no rx crc check
// - Sub-mode bit picks direct mode 0 or 1
// - Codes 01000 to 01011 select type A
// - Codes 01100 to 01111 select type B
// - Codes 11010, 11011 select type F
// - Guard field gives 0 to 7 etu
// - End-of-frame low is 11 or 10 etu
// - Start-of-frame high is 3 or 2 etu
// - Start-of-frame low is 11 or 10 etu
// - Guard after last byte optional by bit
// - Separate rate enable uses tx rate field for type A or B only
// - Tx rate field maps 106 to 848 kbps
// - Tx parity odd, last byte even
// - Rx parity odd, last byte even
// - Type B options reset to 00
// - Type A options clear on control writes
// - Protocol control resets to 02
module rfid_protocol_option_regs (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Enable pin, low holds registers at reset values
  input wire logic enable,
  // Register port
  input rpo_pkg::rpo_req_t req,
  output logic [7:0] rdata,
  // Decoded settings
  output rpo_pkg::rpo_cfg_t cfg
);

  // ==========================================================
  // State
  rpo_pkg::rpo_regs_t state; // Registered state
  rpo_pkg::rpo_regs_t next_state; // Next state
  rpo_pkg::rpo_cfg_t cfg_q; // Registered settings
  rpo_pkg::rpo_cfg_t next_cfg; // Next settings
  rpo_pkg::rpo_proto_t dec_proto; // Decoded family
  logic [1:0] dec_rx_rate; // Decoded receive rate
  logic [3:0] eof_low_etu; // End-of-frame low length
  logic [3:0] sof_high_etu; // Start-of-frame high length
  logic [3:0] sof_low_etu; // Start-of-frame low length

  // ==========================================================
  // Protocol decode of the next control value
  rpo_proto_decode u_decode (
    .code(next_state.protocol_control[rpo_pkg::RPO_PC_CODE_HI:0]),
    .proto(dec_proto),
    .rx_rate(dec_rx_rate)
  );

  // ==========================================================
  // Frame phase lengths
  rpo_etu_select u_eof_low (
    .long_sel(next_state.type_b_tx_options[rpo_pkg::RPO_TB_EOF_LOW]),
    .long_etu(rpo_pkg::RPO_ETU_LOW_LONG),
    .short_etu(rpo_pkg::RPO_ETU_LOW_SHORT),
    .etu(eof_low_etu)
  );

  rpo_etu_select u_sof_high (
    .long_sel(next_state.type_b_tx_options[rpo_pkg::RPO_TB_SOF_HIGH]),
    .long_etu(rpo_pkg::RPO_ETU_HIGH_LONG),
    .short_etu(rpo_pkg::RPO_ETU_HIGH_SHORT),
    .etu(sof_high_etu)
  );

  rpo_etu_select u_sof_low (
    .long_sel(next_state.type_b_tx_options[rpo_pkg::RPO_TB_SOF_LOW]),
    .long_etu(rpo_pkg::RPO_ETU_LOW_LONG),
    .short_etu(rpo_pkg::RPO_ETU_LOW_SHORT),
    .etu(sof_low_etu)
  );

  // ==========================================================
  // Register writes and read data
  always_comb begin
    next_state = state;
    if (!enable) begin
      // Enable low returns every register to reset
      next_state.protocol_control = rpo_pkg::RPO_RST_PROTOCOL_CONTROL;
      next_state.type_b_tx_options = rpo_pkg::RPO_RST_TYPE_B_TX_OPTIONS;
      next_state.type_a_rate_parity_options = rpo_pkg::RPO_RST_TYPE_A_RATE_PARITY;
      next_state.rdata = 8'h00;
    end else begin
      // Write decode
      if (req.wr && req.addr == rpo_pkg::RPO_ADDR_PROTOCOL_CONTROL) begin
        next_state.protocol_control = req.wdata & rpo_pkg::RPO_MASK_PROTOCOL_CONTROL;
        // Control write clears the type A options
        next_state.type_a_rate_parity_options = rpo_pkg::RPO_RST_TYPE_A_RATE_PARITY;
      end else if (req.wr && req.addr == rpo_pkg::RPO_ADDR_TYPE_B_TX_OPTIONS) begin
        next_state.type_b_tx_options = req.wdata & rpo_pkg::RPO_MASK_TYPE_B_TX_OPTIONS;
      end else if (req.wr && req.addr == rpo_pkg::RPO_ADDR_TYPE_A_RATE_PARITY) begin
        next_state.type_a_rate_parity_options =
          req.wdata & rpo_pkg::RPO_MASK_TYPE_A_RATE_PARITY;
      end
      // Read decode, unmapped reads give zero
      if (req.rd && req.addr == rpo_pkg::RPO_ADDR_PROTOCOL_CONTROL) begin
        next_state.rdata = state.protocol_control;
      end else if (req.rd && req.addr == rpo_pkg::RPO_ADDR_TYPE_B_TX_OPTIONS) begin
        next_state.rdata = state.type_b_tx_options;
      end else if (req.rd && req.addr == rpo_pkg::RPO_ADDR_TYPE_A_RATE_PARITY) begin
        next_state.rdata = state.type_a_rate_parity_options;
      end else if (req.rd) begin
        next_state.rdata = 8'h00;
      end
    end
  end

  // ==========================================================
  // Settings derived from the next register values
  always_comb begin
    next_cfg.proto = dec_proto;
    next_cfg.rx_rate = dec_rx_rate;
    // Separate tx rate only for type A or B, at any receive rate
    if (next_state.type_a_rate_parity_options[rpo_pkg::RPO_TA_SEP_RATE] &&
        (dec_proto == rpo_pkg::RPO_PROTO_A || dec_proto == rpo_pkg::RPO_PROTO_B)) begin
      next_cfg.tx_rate = next_state.type_a_rate_parity_options[
        rpo_pkg::RPO_TA_RATE_HI:rpo_pkg::RPO_TA_RATE_LO];
    end else begin
      next_cfg.tx_rate = dec_rx_rate;
    end
    next_cfg.rx_crc_check =
      !next_state.protocol_control[rpo_pkg::RPO_PC_RX_CRC_ABSENT];
    next_cfg.direct_mode1 = next_state.protocol_control[rpo_pkg::RPO_PC_DIRECT_SUB];
    // Type B framing only applies to type B
    if (dec_proto == rpo_pkg::RPO_PROTO_B) begin
      next_cfg.char_guard_etu = next_state.type_b_tx_options[
        rpo_pkg::RPO_TB_GUARD_HI:rpo_pkg::RPO_TB_GUARD_LO];
      next_cfg.guard_after_last =
        next_state.type_b_tx_options[rpo_pkg::RPO_TB_GUARD_LAST];
      next_cfg.frame_end_low_etu = eof_low_etu;
      next_cfg.frame_start_high_etu = sof_high_etu;
      next_cfg.frame_start_low_etu = sof_low_etu;
    end else begin
      next_cfg.char_guard_etu = 3'h0;
      next_cfg.guard_after_last = 1'b0;
      next_cfg.frame_end_low_etu = 4'h0;
      next_cfg.frame_start_high_etu = 4'h0;
      next_cfg.frame_start_low_etu = 4'h0;
    end
    // Parity options only for type A
    if (dec_proto == rpo_pkg::RPO_PROTO_A) begin
      next_cfg.tx_last_byte_even_parity =
        next_state.type_a_rate_parity_options[rpo_pkg::RPO_TA_TX_PAR];
      next_cfg.rx_last_byte_even_parity =
        next_state.type_a_rate_parity_options[rpo_pkg::RPO_TA_RX_PAR];
    end else begin
      next_cfg.tx_last_byte_even_parity = 1'b0;
      next_cfg.rx_last_byte_even_parity = 1'b0;
    end
  end

  // ==========================================================
  // State registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state.protocol_control <= rpo_pkg::RPO_RST_PROTOCOL_CONTROL;
      state.type_b_tx_options <= rpo_pkg::RPO_RST_TYPE_B_TX_OPTIONS;
      state.type_a_rate_parity_options <= rpo_pkg::RPO_RST_TYPE_A_RATE_PARITY;
      state.rdata <= 8'h00;
      cfg_q.proto <= rpo_pkg::RPO_PROTO_NONE;
      cfg_q.rx_rate <= rpo_pkg::RPO_RATE_106;
      cfg_q.tx_rate <= rpo_pkg::RPO_RATE_106;
      cfg_q.rx_crc_check <= 1'b1;
      cfg_q.direct_mode1 <= 1'b0;
      cfg_q.char_guard_etu <= 3'h0;
      cfg_q.guard_after_last <= 1'b0;
      cfg_q.frame_end_low_etu <= 4'h0;
      cfg_q.frame_start_high_etu <= 4'h0;
      cfg_q.frame_start_low_etu <= 4'h0;
      cfg_q.tx_last_byte_even_parity <= 1'b0;
      cfg_q.rx_last_byte_even_parity <= 1'b0;
    end else begin
      state <= next_state;
      cfg_q <= next_cfg;
    end
  end

  // ==========================================================
  // Outputs straight from flip-flops
  assign rdata = state.rdata;
  assign cfg = cfg_q;

endmodule

// *** rfid_protocol_option_regs_tb_top.sv ***
`timescale 1ns/1ps
module rfid_protocol_option_regs_tb_top;
  // ==========================================================
  // Signals, counters and expected image
  logic clk_sys;
  logic rst_b;
  logic enable;
  logic [7:0] rdata;
  rpo_pkg::rpo_req_t req;
  rpo_pkg::rpo_cfg_t cfg;
  int bad_count = 0;
  int checks_done = 0;
  logic [7:0] sh [1:3];
  logic [7:0] expq [$];
  logic rd_seen;
  logic [7:0] v;
  logic [3:0] e;
  logic [4:0] codes [11] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F,
    5'h1A, 5'h1B, 5'h02};

  // Clock, 50 ns period
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  rfid_protocol_option_regs uut (.clk_sys(clk_sys), .rst_b(rst_b), .enable(enable),
    .req(req), .rdata(rdata), .cfg(cfg));
  rpo_host_model host (.clk_sys(clk_sys), .req(req));

  // Compare and count
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
    checks_done++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Write and track the expected register image
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d);
    case (a)
      8'h01: sh = '{d & 8'hDF, sh[2], 8'h00};
      8'h02: sh[2] = d & 8'hFE;
      8'h03: sh[3] = d & 8'hF8;
      default: ;
    endcase
  endtask

  // Read: note the expected byte, then strobe
  task automatic r(input logic [7:0] a);
    expq.push_back((a inside {[8'h01:8'h03]}) ? sh[a[1:0]] : 8'h00);
    host.xfer(1'b0, a, 8'h00);
  endtask

  // Watcher takes the oldest note when read data lands
  always @(posedge clk_sys) rd_seen <= enable && req.rd;
  always @(negedge clk_sys) begin
    if (rd_seen === 1'b1 && rst_b && expq.size() > 0) begin
      chk("rdata", rdata, expq.pop_front());
    end
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    enable = 1'b1;
    void'($urandom(32'h427efab6));
    sh = '{8'h02, 8'h00, 8'h00};
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys) rst_b = 1'b1;
    for (int i = 0; i < 4; i++) r(i[7:0]);
    $display("test reset values done");
    foreach (codes[i]) begin
      v = $urandom;
      w(8'h01, {v[7:6], 1'b0, codes[i]});
      e = codes[i][4] ? 4'h8 : !codes[i][3] ? 4'h1 : codes[i][2] ? 4'h4 : 4'h2;
      chk("proto", cfg.proto, e);
      if (e != 4'h1) chk("rx_rate", cfg.rx_rate, codes[i][1:0] - {1'b0, codes[i][4]});
      chk("crc", cfg.rx_crc_check, !v[7]);
      chk("sub", cfg.direct_mode1, v[6]);
      r(8'h01);
    end
    $display("test protocol codes done");
    w(8'h01, 8'h0C);
    repeat (6) begin
      v = $urandom;
      w(8'h02, v);
      chk("guard", cfg.char_guard_etu, v[7:5]);
      chk("eof", cfg.frame_end_low_etu, v[4] ? 8'h0B : 8'h0A);
      chk("sof_hi", cfg.frame_start_high_etu, v[3] ? 8'h03 : 8'h02);
      chk("sof_lo", cfg.frame_start_low_etu, v[2] ? 8'h0B : 8'h0A);
      chk("last", cfg.guard_after_last, v[1]);
      r(8'h02);
    end
    w(8'h03, 8'hF8);
    chk("tx_rate_b", cfg.tx_rate, 2'h3);
    chk("par_b", cfg.tx_last_byte_even_parity, 1'b0);
    $display("test type B options done");
    w(8'h01, 8'h0A);
    chk("tx_rate_clr", cfg.tx_rate, 2'h2);
    chk("eof_a", cfg.frame_end_low_etu, 8'h00);
    chk("guard_a", cfg.char_guard_etu, 8'h00);
    repeat (6) begin
      v = $urandom;
      w(8'h03, v);
      chk("tx_rate", cfg.tx_rate, v[7] ? v[6:5] : 2'h2);
      chk("tx_par", cfg.tx_last_byte_even_parity, v[4]);
      chk("rx_par", cfg.rx_last_byte_even_parity, v[3]);
      r(8'h03);
    end
    w(8'h01, 8'h0A);
    r(8'h03);
    $display("test type A options done");
    w(8'h02, 8'hFF);
    @(negedge clk_sys) enable = 1'b0;
    host.xfer(1'b1, 8'h01, 8'h8B);
    @(negedge clk_sys) enable = 1'b1;
    sh = '{8'h02, 8'h00, 8'h00};
    r(8'h01);
    r(8'h02);
    w(8'h05, 8'hFF);
    r(8'h05);
    r(8'h03);
    $display("test enable and unmapped done");
    repeat (3) @(negedge clk_sys);
    end_of_test;
  end

  // Watchdog
  initial begin
    #(50 * 4000);
    bad_count++;
    $display("watchdog expired");
    end_of_test;
  end
endmodule

bind rfid_protocol_option_regs rpo_checker chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
  .enable(enable), .req(req), .rdata(rdata), .cfg(cfg));

// *** rpo_checker.sv ***
`timescale 1ns/1ps
// Watches the option register bank at its ports
module rpo_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Inputs
  input wire logic enable,
  input rpo_pkg::rpo_req_t req,
  // Outputs
  input wire logic [7:0] rdata,
  input rpo_pkg::rpo_cfg_t cfg
);
  // ==========================================================
  // Accepted writes per register
  logic w1;
  logic w2;
  logic w3;
  assign w1 = enable && req.wr && req.addr == 8'h01;
  assign w2 = enable && req.wr && req.addr == 8'h02;
  assign w3 = enable && req.wr && req.addr == 8'h03;

  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // Properties
  AST_EN_LOW: assert property (!enable |=> rdata == 8'h00
    && cfg.proto == rpo_pkg::RPO_PROTO_NONE) else $error("enable low did not clear");
  AST_CRC_SUB: assert property (w1 |=> cfg.rx_crc_check == !$past(req.wdata[7])
    && cfg.direct_mode1 == $past(req.wdata[6])) else $error("crc or sub-mode wrong");
  AST_TYPE_A: assert property (w1 && req.wdata[4:2] == 3'h2 |=>
    cfg.proto == rpo_pkg::RPO_PROTO_A && cfg.rx_rate == $past(req.wdata[1:0])
    && cfg.tx_rate == cfg.rx_rate && !cfg.tx_last_byte_even_parity)
    else $error("type A decode wrong");
  AST_TYPE_B: assert property (w1 && req.wdata[4:2] == 3'h3 |=>
    cfg.proto == rpo_pkg::RPO_PROTO_B && cfg.rx_rate == $past(req.wdata[1:0]))
    else $error("type B decode wrong");
  AST_TYPE_F: assert property (w1 && req.wdata[4:1] == 4'hD |=>
    cfg.proto == rpo_pkg::RPO_PROTO_F) else $error("type F decode wrong");
  AST_UNLISTED: assert property (w1 && req.wdata[4:3] == 2'h0 |=>
    cfg.proto == rpo_pkg::RPO_PROTO_NONE) else $error("unlisted code selected");
  AST_FRAME_LEN: assert property (w2 && cfg.proto == rpo_pkg::RPO_PROTO_B |=>
    cfg.frame_end_low_etu == ($past(req.wdata[4]) ? 4'hB : 4'hA)
    && cfg.frame_start_high_etu == ($past(req.wdata[3]) ? 4'h3 : 4'h2)
    && cfg.frame_start_low_etu == ($past(req.wdata[2]) ? 4'hB : 4'hA))
    else $error("frame lengths wrong");
  AST_GUARD: assert property (w2 && cfg.proto == rpo_pkg::RPO_PROTO_B |=>
    cfg.char_guard_etu == $past(req.wdata[7:5]) && cfg.guard_after_last == $past(req.wdata[1]))
    else $error("guard settings wrong");
  AST_TX_RATE: assert property (w3 && cfg.proto == rpo_pkg::RPO_PROTO_A |=>
    cfg.tx_rate == ($past(req.wdata[7]) ? $past(req.wdata[6:5]) : cfg.rx_rate))
    else $error("tx rate wrong");
  AST_PARITY: assert property (w3 && cfg.proto == rpo_pkg::RPO_PROTO_A |=>
    cfg.tx_last_byte_even_parity == $past(req.wdata[4])
    && cfg.rx_last_byte_even_parity == $past(req.wdata[3])) else $error("parity options wrong");

  // Main scenarios reached
  cover property (w1 && req.wdata[4:1] == 4'hD);
  cover property (w2 && cfg.proto == rpo_pkg::RPO_PROTO_B);
  cover property (!enable);
endmodule

// *** rpo_etu_select.sv ***
`timescale 1ns/1ps
// Picks a long or short frame phase length
module rpo_etu_select (
  // Select and choices
  input wire logic long_sel,
  input wire logic [3:0] long_etu,
  input wire logic [3:0] short_etu,
  // Chosen length
  output logic [3:0] etu
);

  // ==========================================================
  // Selector
  assign etu = long_sel ? long_etu : short_etu;

endmodule

// *** rpo_host_model.sv ***
`timescale 1ns/1ps
// Host side of the register port
module rpo_host_model (
  // Clock
  input wire logic clk_sys,
  // Request to the bank
  output rpo_pkg::rpo_req_t req
);
  initial req = '0;
  // One strobe held across one rising edge; released lines show inverted bits
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= {wr, !wr, a, (a == 8'h01) ? (d & 8'hDF) : d};
    @(negedge clk_sys);
    req <= {2'b00, ~a, ~d};
  endtask
endmodule

// *** rpo_pkg.sv ***
package rpo_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] RPO_ADDR_PROTOCOL_CONTROL = 8'h01;
  localparam logic [7:0] RPO_ADDR_TYPE_B_TX_OPTIONS = 8'h02;
  localparam logic [7:0] RPO_ADDR_TYPE_A_RATE_PARITY = 8'h03;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RPO_RST_PROTOCOL_CONTROL = 8'h02;
  localparam logic [7:0] RPO_RST_TYPE_B_TX_OPTIONS = 8'h00;
  localparam logic [7:0] RPO_RST_TYPE_A_RATE_PARITY = 8'h00;

  // ==========================================================
  // Writable bit masks; unused positions read zero
  localparam logic [7:0] RPO_MASK_PROTOCOL_CONTROL = 8'hFF;
  localparam logic [7:0] RPO_MASK_TYPE_B_TX_OPTIONS = 8'hFE;
  localparam logic [7:0] RPO_MASK_TYPE_A_RATE_PARITY = 8'hF8;

  // ==========================================================
  // Protocol control field positions
  localparam int RPO_PC_RX_CRC_ABSENT = 7;
  localparam int RPO_PC_DIRECT_SUB = 6;
  localparam int RPO_PC_TAG_READER = 5;
  localparam int RPO_PC_CODE_HI = 4;

  // Type B option field positions
  localparam int RPO_TB_GUARD_HI = 7;
  localparam int RPO_TB_GUARD_LO = 5;
  localparam int RPO_TB_EOF_LOW = 4;
  localparam int RPO_TB_SOF_HIGH = 3;
  localparam int RPO_TB_SOF_LOW = 2;
  localparam int RPO_TB_GUARD_LAST = 1;

  // Type A option field positions
  localparam int RPO_TA_SEP_RATE = 7;
  localparam int RPO_TA_RATE_HI = 6;
  localparam int RPO_TA_RATE_LO = 5;
  localparam int RPO_TA_TX_PAR = 4;
  localparam int RPO_TA_RX_PAR = 3;

  // ==========================================================
  // Protocol codes
  localparam logic [4:0] RPO_CODE_A_106 = 5'h08;
  localparam logic [4:0] RPO_CODE_A_212 = 5'h09;
  localparam logic [4:0] RPO_CODE_A_424 = 5'h0A;
  localparam logic [4:0] RPO_CODE_A_848 = 5'h0B;
  localparam logic [4:0] RPO_CODE_B_106 = 5'h0C;
  localparam logic [4:0] RPO_CODE_B_212 = 5'h0D;
  localparam logic [4:0] RPO_CODE_B_424 = 5'h0E;
  localparam logic [4:0] RPO_CODE_B_848 = 5'h0F;
  localparam logic [4:0] RPO_CODE_F_212 = 5'h1A;
  localparam logic [4:0] RPO_CODE_F_424 = 5'h1B;

  // ==========================================================
  // Frame lengths in elementary time units
  localparam logic [3:0] RPO_ETU_LOW_LONG = 4'hB;
  localparam logic [3:0] RPO_ETU_LOW_SHORT = 4'hA;
  localparam logic [3:0] RPO_ETU_HIGH_LONG = 4'h3;
  localparam logic [3:0] RPO_ETU_HIGH_SHORT = 4'h2;

  // Rate encodings (also match 2-bit tx rate field)
  localparam logic [1:0] RPO_RATE_106 = 2'h0;
  localparam logic [1:0] RPO_RATE_212 = 2'h1;
  localparam logic [1:0] RPO_RATE_424 = 2'h2;
  localparam logic [1:0] RPO_RATE_848 = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    RPO_PROTO_NONE = 4'h1,
    RPO_PROTO_A = 4'h2,
    RPO_PROTO_B = 4'h4,
    RPO_PROTO_F = 4'h8
  } rpo_proto_t;

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpo_req_t;

  // Decoded settings for framing logic
  typedef struct packed {
    rpo_proto_t proto;
    logic [1:0] rx_rate;
    logic [1:0] tx_rate;
    logic rx_crc_check;
    logic direct_mode1;
    logic [2:0] char_guard_etu;
    logic guard_after_last;
    logic [3:0] frame_end_low_etu;
    logic [3:0] frame_start_high_etu;
    logic [3:0] frame_start_low_etu;
    logic tx_last_byte_even_parity;
    logic rx_last_byte_even_parity;
  } rpo_cfg_t;

  // Register bank state
  typedef struct packed {
    logic [7:0] protocol_control;
    logic [7:0] type_b_tx_options;
    logic [7:0] type_a_rate_parity_options;
    logic [7:0] rdata;
  } rpo_regs_t;

endpackage

// *** rpo_proto_decode.sv ***
`timescale 1ns/1ps
// Maps the 5-bit protocol code to a family and a receive rate
module rpo_proto_decode (
  // Code in
  input wire logic [4:0] code,
  // Decoded family and rate
  output rpo_pkg::rpo_proto_t proto,
  output logic [1:0] rx_rate
);

  // ==========================================================
  // Decoder
  always_comb begin
    proto = rpo_pkg::RPO_PROTO_NONE;
    rx_rate = rpo_pkg::RPO_RATE_106;
    case (code)
      rpo_pkg::RPO_CODE_A_106: begin
        proto = rpo_pkg::RPO_PROTO_A;
      end
      rpo_pkg::RPO_CODE_A_212: begin
        proto = rpo_pkg::RPO_PROTO_A;
        rx_rate = rpo_pkg::RPO_RATE_212;
      end
      rpo_pkg::RPO_CODE_A_424: begin
        proto = rpo_pkg::RPO_PROTO_A;
        rx_rate = rpo_pkg::RPO_RATE_424;
      end
      rpo_pkg::RPO_CODE_A_848: begin
        proto = rpo_pkg::RPO_PROTO_A;
        rx_rate = rpo_pkg::RPO_RATE_848;
      end
      rpo_pkg::RPO_CODE_B_106: begin
        proto = rpo_pkg::RPO_PROTO_B;
      end
      rpo_pkg::RPO_CODE_B_212: begin
        proto = rpo_pkg::RPO_PROTO_B;
        rx_rate = rpo_pkg::RPO_RATE_212;
      end
      rpo_pkg::RPO_CODE_B_424: begin
        proto = rpo_pkg::RPO_PROTO_B;
        rx_rate = rpo_pkg::RPO_RATE_424;
      end
      rpo_pkg::RPO_CODE_B_848: begin
        proto = rpo_pkg::RPO_PROTO_B;
        rx_rate = rpo_pkg::RPO_RATE_848;
      end
      rpo_pkg::RPO_CODE_F_212: begin
        proto = rpo_pkg::RPO_PROTO_F;
        rx_rate = rpo_pkg::RPO_RATE_212;
      end
      rpo_pkg::RPO_CODE_F_424: begin
        proto = rpo_pkg::RPO_PROTO_F;
        rx_rate = rpo_pkg::RPO_RATE_424;
      end
      default: begin
        proto = rpo_pkg::RPO_PROTO_NONE;
      end
    endcase
  end

endmodule
